// [vtsup_regs.svh]
// Constants for the voltage transformer supervisor.
// Summary of operation
// - Four channel magnitudes and angles arrive on a 5 ms update tick.
// - Pick-up when any of three voltages is below the low threshold.
// - Pick-up when two or more of three voltages exceed the high threshold.
// - Each phase continuously compares settings against its measured magnitude.
// - Angle shift below limit versus 40 ms earlier on all three phases blocks voltage pick-up; fuse pick-up is not blocked.
// - Bus fuse check setting, default yes, supervises the bus breaker-trip input.
// - Line fuse check setting, default yes, supervises the line breaker-trip input.
// - Mode selects on, blocked, test, test-blocked or off; mode is reported.
// - Status override to a chosen condition applies only with global forcing enabled.
// - Mode and override are static, not taken from the setting group.
// - Thresholds, angle limit and fuse checks change live without restart.
// - Bus state is dead, healthy normal, reversed, undefined, or problem.
// - Problem bus state whenever any pick-up condition holds.
// - Condition output reports normal, start, line fail, bus fail or blocked.
// - Expected operating time is reported in 5 ms steps up to 1800 s.
// - Blocking at pick-up gives blocked; an active start is reset by blocking.
// - Pick-up to operation uses a definite time delay.
`ifndef VTSUP_REGS_SVH
`define VTSUP_REGS_SVH
`define VTSUP_TICK_MS 5
`define VTSUP_HIST_MS 40
`define VTSUP_HIST_DEPTH (`VTSUP_HIST_MS / `VTSUP_TICK_MS)
`define VTSUP_LOW_RST 8'h05
`define VTSUP_HIGH_RST 8'h50
`define VTSUP_ANGLE_RST 16'h01F4
`define VTSUP_MAX_TIME 19'h5_7E40
`define VTSUP_DEAD_LVL 8'h05
`endif

// [vtsup_pkg.sv]
// Types for the voltage transformer supervisor.
package vtsup_pkg;
  typedef enum logic [2:0] {
    VTSUP_MODE_ON = 3'h0,
    VTSUP_MODE_BLOCKED = 3'h1,
    VTSUP_MODE_TEST = 3'h2,
    VTSUP_MODE_TEST_BLOCKED = 3'h3,
    VTSUP_MODE_OFF = 3'h4
  } vtsup_mode_t;
  typedef enum logic [2:0] {
    VTSUP_COND_NORMAL = 3'h0,
    VTSUP_COND_START = 3'h1,
    VTSUP_COND_LINE_FAIL = 3'h3,
    VTSUP_COND_BUS_FAIL = 3'h2,
    VTSUP_COND_BLOCKED = 3'h6
  } vtsup_cond_t;
  typedef enum logic [2:0] {
    VTSUP_BUS_DEAD = 3'h0,
    VTSUP_BUS_OK_NORMAL = 3'h1,
    VTSUP_BUS_OK_REVERSED = 3'h2,
    VTSUP_BUS_OK_UNDEFINED = 3'h3,
    VTSUP_BUS_PROBLEM = 3'h4
  } vtsup_bus_t;
  typedef enum logic [1:0] {
    VTSUP_SEQ_NORMAL = 2'h0,
    VTSUP_SEQ_REVERSED = 2'h1,
    VTSUP_SEQ_UNDEFINED = 2'h2
  } vtsup_seq_t;
  // Magnitudes in 0.01 of nominal, angles in 0.01 degree.
  typedef struct packed {
    logic [7:0] mag;
    logic [15:0] angle;
  } vtsup_chan_t;
  // Group settings; thresholds in 0.01 of nominal, angle limit in 0.01 degree.
  typedef struct packed {
    logic [7:0] low_pickup;
    logic [7:0] high_detect;
    logic [15:0] angle_limit;
    logic bus_fuse_check;
    logic line_fuse_check;
    logic [18:0] delay_ticks;
  } vtsup_group_t;
endpackage

// [vtsup_supervisor.sv]
// Voltage transformer supervisor core.
`timescale 1ns/1ps
`include "vtsup_regs.svh"
module vtsup_supervisor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic meas_tick,
  input wire vtsup_pkg::vtsup_chan_t chan1_fundamental_mag,
  input wire vtsup_pkg::vtsup_chan_t chan2_fundamental_mag,
  input wire vtsup_pkg::vtsup_chan_t chan3_fundamental_mag,
  input wire vtsup_pkg::vtsup_chan_t chan4_fundamental_mag,
  input wire vtsup_pkg::vtsup_seq_t sequence_state,
  input wire vtsup_pkg::vtsup_group_t group_settings,
  input wire vtsup_pkg::vtsup_mode_t node_operating_mode,
  input wire vtsup_pkg::vtsup_cond_t status_override,
  input wire logic forcing_enable,
  input wire logic block_in,
  input wire logic bus_breaker_trip_input,
  input wire logic line_breaker_trip_input,
  output vtsup_pkg::vtsup_mode_t mode_in_effect,
  output vtsup_pkg::vtsup_cond_t supervision_condition,
  output vtsup_pkg::vtsup_bus_t bus_state,
  output logic line_transformer_failure,
  output logic bus_transformer_failure,
  output logic [2:0] low_ratio_flags,
  output logic [2:0] high_ratio_flags,
  output logic [18:0] expected_time,
  output logic signed [19:0] time_remaining
);
  import vtsup_pkg::*;

  // ****************************************
  // Input synchronisers for the pin inputs.
  // ****************************************
  logic [2:0] blk_sync_ff;
  logic [2:0] bus_sync_ff;
  logic [2:0] line_sync_ff;
  logic blk_ff;
  logic bus_trip_ff;
  logic line_trip_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      blk_sync_ff <= 3'h0;
      bus_sync_ff <= 3'h0;
      line_sync_ff <= 3'h0;
    end else begin
      blk_sync_ff <= {blk_sync_ff[1:0], block_in};
      bus_sync_ff <= {bus_sync_ff[1:0], bus_breaker_trip_input};
      line_sync_ff <= {line_sync_ff[1:0], line_breaker_trip_input};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      blk_ff <= 1'b0;
      bus_trip_ff <= 1'b0;
      line_trip_ff <= 1'b0;
    end else begin
      if (blk_sync_ff[1] == blk_sync_ff[2]) begin
        blk_ff <= blk_sync_ff[2];
      end
      if (bus_sync_ff[1] == bus_sync_ff[2]) begin
        bus_trip_ff <= bus_sync_ff[2];
      end
      if (line_sync_ff[1] == line_sync_ff[2]) begin
        line_trip_ff <= line_sync_ff[2];
      end
    end
  end

  // ****************************************
  // Angle history and shift detection.
  // ****************************************
  function automatic logic [15:0] angle_diff(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] d;
    d = (a >= b) ? (a - b) : (b - a);
    if (d > 16'h4650) begin
      d = 16'h8CA0 - d;
    end
    return d;
  endfunction

  logic [15:0] hist_ff [0:3][0:`VTSUP_HIST_DEPTH-1];
  logic [3:0] shift_ok;
  vtsup_chan_t chans [0:3];

  always_comb begin
    chans[0] = chan1_fundamental_mag;
    chans[1] = chan2_fundamental_mag;
    chans[2] = chan3_fundamental_mag;
    chans[3] = chan4_fundamental_mag;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int c = 0; c < 4; c++) begin
        for (int k = 0; k < `VTSUP_HIST_DEPTH; k++) begin
          hist_ff[c][k] <= 16'h0000;
        end
      end
    end else if (meas_tick) begin
      for (int c = 0; c < 4; c++) begin
        hist_ff[c][0] <= chans[c].angle;
        for (int k = 1; k < `VTSUP_HIST_DEPTH; k++) begin
          hist_ff[c][k] <= hist_ff[c][k-1];
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      // Oldest entry is the angle 40 ms ago.
      shift_ok[c] = angle_diff(chans[c].angle, hist_ff[c][`VTSUP_HIST_DEPTH-1])
                    >= group_settings.angle_limit;
    end
  end

  // ****************************************
  // Pick-up evaluation.
  // ****************************************
  function automatic logic two_of_three(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  logic [2:0] low_cmp;
  logic [2:0] high_cmp;
  logic [2:0] live_cmp;
  logic volt_pickup;
  logic fuse_pickup;
  logic pickup;

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      low_cmp[p] = chans[p].mag < group_settings.low_pickup;
      high_cmp[p] = chans[p].mag > group_settings.high_detect;
      live_cmp[p] = chans[p].mag >= `VTSUP_DEAD_LVL;
    end
    volt_pickup = ((|low_cmp) || two_of_three(high_cmp)) && (|shift_ok[2:0]);
    fuse_pickup = (group_settings.bus_fuse_check && bus_trip_ff)
                  || (group_settings.line_fuse_check && line_trip_ff);
    pickup = volt_pickup || fuse_pickup;
  end

  // ****************************************
  // Definite-time delay and condition.
  // ****************************************
  logic [18:0] elapsed_ff;
  logic start_ff;
  logic blocked_ff;
  logic fail_ff;
  logic bus_side_ff;
  logic mode_blocks;
  logic mode_off;
  logic tick_clear;
  logic tick_block;
  logic tick_run;
  logic delay_done;

  always_comb begin
    mode_off = (node_operating_mode == VTSUP_MODE_OFF);
    mode_blocks = (node_operating_mode == VTSUP_MODE_BLOCKED)
                  || (node_operating_mode == VTSUP_MODE_TEST_BLOCKED) || blk_ff;
    tick_clear = meas_tick && (mode_off || !pickup);
    tick_block = meas_tick && !tick_clear && mode_blocks;
    tick_run = meas_tick && !tick_clear && !mode_blocks;
    // Widened so that the largest delay setting cannot wrap the compare.
    delay_done = ({1'b0, elapsed_ff} + 20'h0_0001) >= {1'b0, group_settings.delay_ticks};
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      elapsed_ff <= 19'h0_0000;
    end else if (tick_clear || tick_block) begin
      elapsed_ff <= 19'h0_0000;
    end else if (tick_run) begin
      elapsed_ff <= delay_done ? group_settings.delay_ticks : elapsed_ff + 19'h0_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      start_ff <= 1'b0;
    end else if (tick_clear || tick_block) begin
      start_ff <= 1'b0;
    end else if (tick_run) begin
      start_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      blocked_ff <= 1'b0;
    end else if (tick_clear || tick_run) begin
      blocked_ff <= 1'b0;
    end else if (tick_block) begin
      blocked_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fail_ff <= 1'b0;
    end else if (tick_clear || tick_block) begin
      fail_ff <= 1'b0;
    end else if (tick_run && delay_done) begin
      fail_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_side_ff <= 1'b0;
    end else if (tick_run) begin
      bus_side_ff <= group_settings.bus_fuse_check && bus_trip_ff;
    end
  end

  // ****************************************
  // Reported states.
  // ****************************************
  vtsup_cond_t cond;
  always_comb begin
    if (blocked_ff) begin
      cond = VTSUP_COND_BLOCKED;
    end else if (fail_ff) begin
      cond = bus_side_ff ? VTSUP_COND_BUS_FAIL : VTSUP_COND_LINE_FAIL;
    end else if (start_ff) begin
      cond = VTSUP_COND_START;
    end else begin
      cond = VTSUP_COND_NORMAL;
    end
    if (forcing_enable) begin
      cond = status_override;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_in_effect <= VTSUP_MODE_ON;
      supervision_condition <= VTSUP_COND_NORMAL;
      line_transformer_failure <= 1'b0;
      bus_transformer_failure <= 1'b0;
    end else begin
      mode_in_effect <= node_operating_mode;
      supervision_condition <= cond;
      line_transformer_failure <= (cond == VTSUP_COND_LINE_FAIL);
      bus_transformer_failure <= (cond == VTSUP_COND_BUS_FAIL);
    end
  end

  function automatic logic [18:0] clamp_time(input logic [18:0] t);
    return (t > `VTSUP_MAX_TIME) ? `VTSUP_MAX_TIME : t;
  endfunction

  function automatic logic signed [19:0] ticks_left(input logic [18:0] total, input logic [18:0] used);
    return $signed({1'b0, total}) - $signed({1'b0, used});
  endfunction

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      low_ratio_flags <= 3'h0;
      high_ratio_flags <= 3'h0;
    end else if (meas_tick) begin
      low_ratio_flags <= low_cmp;
      high_ratio_flags <= high_cmp;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_state <= VTSUP_BUS_DEAD;
    end else if (meas_tick) begin
      if (volt_pickup || fuse_pickup) begin
        bus_state <= VTSUP_BUS_PROBLEM;
      end else if (live_cmp == 3'h0) begin
        bus_state <= VTSUP_BUS_DEAD;
      end else if (sequence_state == VTSUP_SEQ_REVERSED) begin
        bus_state <= VTSUP_BUS_OK_REVERSED;
      end else if (sequence_state == VTSUP_SEQ_UNDEFINED) begin
        bus_state <= VTSUP_BUS_OK_UNDEFINED;
      end else begin
        bus_state <= VTSUP_BUS_OK_NORMAL;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      expected_time <= 19'h0_0000;
    end else begin
      expected_time <= clamp_time(group_settings.delay_ticks);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      time_remaining <= 20'sh0_0000;
    end else if (start_ff) begin
      time_remaining <= ticks_left(group_settings.delay_ticks, elapsed_ff);
    end else begin
      time_remaining <= 20'sh0_0000;
    end
  end
endmodule

// [vtsup_checker_sva.sv]
// Assertion checker for the supervisor ports.
`timescale 1ns/1ps
`include "vtsup_regs.svh"
module vtsup_checker
  import vtsup_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic meas_tick,
  input wire vtsup_pkg::vtsup_chan_t chan1_fundamental_mag,
  input wire vtsup_pkg::vtsup_chan_t chan2_fundamental_mag,
  input wire vtsup_pkg::vtsup_chan_t chan3_fundamental_mag,
  input wire vtsup_pkg::vtsup_group_t group_settings,
  input wire vtsup_pkg::vtsup_mode_t node_operating_mode,
  input wire vtsup_pkg::vtsup_cond_t status_override,
  input wire logic forcing_enable,
  input wire vtsup_pkg::vtsup_mode_t mode_in_effect,
  input wire vtsup_pkg::vtsup_cond_t supervision_condition,
  input wire logic line_transformer_failure,
  input wire logic [2:0] low_ratio_flags,
  input wire logic [2:0] high_ratio_flags,
  input wire logic [18:0] expected_time,
  input wire logic signed [19:0] time_remaining
);
  // ****
  // Per phase comparisons.
  // ****
  logic [2:0] lo;
  logic [2:0] hi;
  logic off_q;
  assign lo = {chan3_fundamental_mag.mag < group_settings.low_pickup,
    chan2_fundamental_mag.mag < group_settings.low_pickup, chan1_fundamental_mag.mag < group_settings.low_pickup};
  assign hi = {chan3_fundamental_mag.mag > group_settings.high_detect,
    chan2_fundamental_mag.mag > group_settings.high_detect, chan1_fundamental_mag.mag > group_settings.high_detect};
  assign off_q = node_operating_mode == VTSUP_MODE_OFF && !forcing_enable;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  AST_MODE: assert property (!$past(sys_rst) |-> mode_in_effect == $past(node_operating_mode))
    else $error("mode lag");
  AST_OFF: assert property (
    off_q [*2] ##0 meas_tick ##1 off_q [*3] |-> supervision_condition == VTSUP_COND_NORMAL && !line_transformer_failure)
    else $error("off not idle");
  AST_FORCE: assert property (
    meas_tick ##0 (forcing_enable && $stable(status_override)) [*4] |-> supervision_condition == status_override)
    else $error("force lost");
  AST_EXP: assert property (
    meas_tick ##0 $stable(group_settings.delay_ticks) [*3] |-> expected_time ==
    (group_settings.delay_ticks > `VTSUP_MAX_TIME ? `VTSUP_MAX_TIME : group_settings.delay_ticks))
    else $error("expected time");
  AST_LOW: assert property (meas_tick |=> low_ratio_flags == $past(lo))
    else $error("low flags");
  AST_HIGH: assert property (meas_tick |=> high_ratio_flags == $past(hi))
    else $error("high flags");
  AST_FAIL: assert property (
    $rose(line_transformer_failure) && !$past(forcing_enable) && !$past(forcing_enable, 2) |-> $past(meas_tick, 2))
    else $error("fail off tick");
  AST_REMAIN: assert property (
    (supervision_condition == VTSUP_COND_NORMAL && !forcing_enable) [*3] |-> $past(time_remaining) == 0)
    else $error("remaining not zero");
endmodule
bind vtsup_supervisor vtsup_checker vtsup_checker_inst (.clock(clock), .sys_rst(sys_rst), .meas_tick(meas_tick),
  .chan1_fundamental_mag(chan1_fundamental_mag), .chan2_fundamental_mag(chan2_fundamental_mag),
  .chan3_fundamental_mag(chan3_fundamental_mag), .group_settings(group_settings),
  .node_operating_mode(node_operating_mode), .status_override(status_override), .forcing_enable(forcing_enable),
  .mode_in_effect(mode_in_effect), .supervision_condition(supervision_condition),
  .line_transformer_failure(line_transformer_failure), .low_ratio_flags(low_ratio_flags),
  .high_ratio_flags(high_ratio_flags), .expected_time(expected_time), .time_remaining(time_remaining));

// [vtsup_meas_model.sv]
// Measurement channel model feeding the supervisor.
`timescale 1ns/1ps
module vtsup_meas_model
  import vtsup_pkg::*;
#(
  parameter int TICK = 20
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [23:0] mags,
  input wire logic [15:0] step,
  output logic meas_tick,
  output vtsup_pkg::vtsup_chan_t chan1,
  output vtsup_pkg::vtsup_chan_t chan2,
  output vtsup_pkg::vtsup_chan_t chan3,
  output vtsup_pkg::vtsup_chan_t chan4
);
  // ****
  // Update tick with advancing angles.
  // ****
  int cnt;
  logic [15:0] ang;
  // Angles stay within one turn, as the supervisor expects.
  function automatic logic [15:0] wrap(input logic [16:0] a);
    return (a >= 17'h0_8CA0) ? 16'(a - 17'h0_8CA0) : a[15:0];
  endfunction
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt <= 0;
      meas_tick <= 1'b0;
      ang <= 16'h0000;
    end else begin
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      meas_tick <= (cnt == TICK - 1);
      if (cnt == TICK - 1) begin
        ang <= wrap({1'b0, ang} + {1'b0, step});
      end
    end
  end
  assign chan1 = {mags[7:0], ang};
  assign chan2 = {mags[15:8], wrap({1'b0, ang} + 17'h0_2EE0)};
  assign chan3 = {mags[23:16], wrap({1'b0, ang} + 17'h0_5DC0)};
  assign chan4 = chan1;
endmodule

// [vtsup_supervisor_tb.sv]
// Self-checking testbench for the supervisor.
`timescale 1ns/1ps
module vtsup_supervisor_tb;
  import vtsup_pkg::*;
  logic clock, sys_rst, meas_tick, fe, blk, btrip, ltrip, lf, bf;
  vtsup_chan_t c1, c2, c3, c4;
  vtsup_seq_t seq;
  vtsup_group_t grp;
  vtsup_mode_t mode, mode_o;
  vtsup_cond_t ovr, cond;
  vtsup_bus_t bus;
  logic [2:0] lowf, highf;
  logic [18:0] exp_t;
  logic signed [19:0] rem;
  logic [23:0] mags;
  logic [15:0] step;
  int err_total, comparisons;
  vtsup_meas_model #(.TICK(20)) vtsup_meas_model_inst (.clock(clock), .sys_rst(sys_rst), .mags(mags),
    .step(step), .meas_tick(meas_tick), .chan1(c1), .chan2(c2), .chan3(c3), .chan4(c4));
  vtsup_supervisor vtsup_supervisor_inst (.clock(clock), .sys_rst(sys_rst), .meas_tick(meas_tick),
    .chan1_fundamental_mag(c1), .chan2_fundamental_mag(c2), .chan3_fundamental_mag(c3),
    .chan4_fundamental_mag(c4), .sequence_state(seq), .group_settings(grp), .node_operating_mode(mode),
    .status_override(ovr), .forcing_enable(fe), .block_in(blk), .bus_breaker_trip_input(btrip),
    .line_breaker_trip_input(ltrip), .mode_in_effect(mode_o), .supervision_condition(cond),
    .bus_state(bus), .line_transformer_failure(lf), .bus_transformer_failure(bf),
    .low_ratio_flags(lowf), .high_ratio_flags(highf), .expected_time(exp_t), .time_remaining(rem));
  // ****
  // Tasks.
  // ****
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input int n);
    int c;
    repeat (n) begin
      c = 0;
      do begin
        @(posedge clock);
        c++;
      end while (meas_tick !== 1'b1 && c < 50);
      if (c >= 50) begin
        err_total++;
        end_sim();
      end
    end
    repeat (5) @(posedge clock);
    #1;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
  initial begin
    {sys_rst, fe, blk, btrip, ltrip} = 5'h10;
    seq = VTSUP_SEQ_NORMAL;
    mode = VTSUP_MODE_ON;
    ovr = VTSUP_COND_NORMAL;
    grp = {8'h05, 8'h50, 16'h01F4, 1'b1, 1'b1, 19'h0_0004};
    mags = 24'h32_3232;
    step = 16'h0064;
    repeat (3) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    chk(cond, VTSUP_COND_NORMAL);
    run(10);
    chk(exp_t, 19'h0_0004);
    for (int i = 0; i < 3; i++) begin
      seq = vtsup_seq_t'(i);
      run(1);
      chk(bus, i + 1);
    end
    mags = 24'h32_3202;
    run(2);
    chk({lowf, cond, lf}, {3'h1, VTSUP_COND_START, 1'b0});
    chk({bus, rem > 0}, {VTSUP_BUS_PROBLEM, 1'b1});
    chk(rem, 20'h0_0002);
    run(4);
    chk({cond, lf, bf}, {VTSUP_COND_LINE_FAIL, 2'h2});
    mags = 24'h5A_5A32;
    run(1);
    chk({highf, bus}, {3'h6, VTSUP_BUS_PROBLEM});
    blk = 1'b1;
    run(1);
    chk(cond, VTSUP_COND_BLOCKED);
    chk(rem, 20'h0_0000);
    {blk, mags} = 25'h32_3232;
    run(1);
    chk({cond, lf}, {VTSUP_COND_NORMAL, 1'b0});
    step = 16'h0000;
    run(9);
    mags = 24'h32_3202;
    run(2);
    chk(cond, VTSUP_COND_NORMAL);
    mags = 24'h00_0000;
    run(1);
    chk(bus, VTSUP_BUS_DEAD);
    {mags, step} = 40'h32_3232_0064;
    run(9);
    grp.low_pickup = 8'h40;
    run(1);
    chk(lowf, 3'h7);
    grp.low_pickup = 8'h05;
    grp.delay_ticks = 19'h7_FFFF;
    run(1);
    chk(exp_t, 19'h5_7E40);
    grp.delay_ticks = 19'h0_0004;
    btrip = 1'b1;
    run(6);
    chk({bf, cond}, {1'b1, VTSUP_COND_BUS_FAIL});
    grp.bus_fuse_check = 1'b0;
    run(1);
    chk(bf, 1'b0);
    {btrip, ltrip, grp.line_fuse_check} = 3'h2;
    run(6);
    chk(lf, 1'b0);
    grp.line_fuse_check = 1'b1;
    run(6);
    chk(lf, 1'b1);
    ltrip = 1'b0;
    for (int i = 0; i < 5; i++) begin
      mode = vtsup_mode_t'(i);
      run(1);
      chk(mode_o, i);
    end
    mags = 24'h32_3202;
    run(6);
    chk({cond, lf}, {VTSUP_COND_NORMAL, 1'b0});
    {mode, mags, fe} = {VTSUP_MODE_ON, 24'h32_3232, 1'b1};
    for (int i = 0; i < 5; i++) begin
      run(1);
      chk(cond, ovr);
      ovr = ovr.next();
    end
    {fe, ovr} = {1'b0, VTSUP_COND_BLOCKED};
    run(2);
    chk(cond, VTSUP_COND_NORMAL);
    end_sim();
  end
endmodule
